// ---- logic/sfr_cfg.svh ----
// Constants of the serial flash read link, shared by both ends
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH

`define SFR_OP_FAST 8'h0B
`define SFR_OP_SLOW 8'h03
`define SFR_OP_PAGE 8'hD2
`define SFR_OP_BUF_FAST 8'hD4
`define SFR_OP_BUF_SLOW 8'hD1

`define SFR_HDR_FAST 7'h28
`define SFR_HDR_SLOW 7'h20
`define SFR_HDR_PAGE 7'h40
`define SFR_HDR_BUF 7'h28
`define SFR_HDR_NONE 7'h08

`define SFR_CNT_OP_LAST 7'h07
`define SFR_CNT_ADDR_LAST 7'h1F
`define SFR_CNT_MAX 7'h7F

`define SFR_LAST_264 9'h107
`define SFR_LAST_256 9'h0FF

`define SFR_CLK_MHZ 20
`define SFR_SLOW_LIMIT_MHZ 33
`define SFR_FAST_LIMIT_MHZ 66
`define SFR_CLK_PERIOD_NS 50
`define SFR_SCK_HALF_NS 300
`define SFR_SCK_HALF \
    4'((`SFR_SCK_HALF_NS + `SFR_CLK_PERIOD_NS - 1) / `SFR_CLK_PERIOD_NS)

`endif

// ---- logic/sfr_dev.sv ----
// Flash device end: read opcodes, address decode and output shifting
`timescale 1ns/100ps
`include "sfr_cfg.svh"
module sfr_dev (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PAGE_256,
    input wire sfr_pkg::sfr_byte_t RD_DATA,
    output sfr_pkg::sfr_ptr_t ADDR_PAGE,
    output sfr_pkg::sfr_ptr_t ADDR_BYTE,
    output logic SEL_BUF,
    output logic READ_ACTIVE,
    sfr_link_if.dev LNK
);
    import sfr_pkg::*;

    // Both page sizes address 512 pages; only the split point moves
    function automatic sfr_ptr_t page_field(logic bin, sfr_addr_t a);
        return bin ? a[16:8] : a[17:9];
    endfunction

    // In 256 mode the ninth offset bit is forced low
    function automatic sfr_ptr_t byte_field(logic bin, sfr_addr_t a);
        return bin ? {1'b0, a[7:0]} : a[8:0];
    endfunction

    // Link side, clocked by the serial clock
    logic link_rst;
    sfr_cnt_t cnt_q;
    sfr_cnt_t cnt_d;
    logic [23:0] sr_q;
    sfr_op_t op_q;
    logic op_ok_q;
    sfr_ptr_t page_q;
    sfr_ptr_t byte_q;
    logic sel_buf_q;
    logic so_q;
    logic so_oe_q;
    logic [6:0] hold_q;
    logic p256;

    // Decode of the frame position
    sfr_op_t op_in;
    sfr_addr_t addr_in;
    sfr_cnt_t hdr;
    logic op_done;
    logic addr_done;
    logic in_data;
    logic byte_end;
    logic first_bit;

    // Mode of the current opcode
    logic is_array;
    logic is_buf_in;

    // Pointer arithmetic
    sfr_ptr_t last_byte;
    logic at_end;
    sfr_ptr_t start_page;
    sfr_ptr_t start_byte;
    sfr_ptr_t next_page;
    sfr_ptr_t next_byte;

    // Output bit selection
    logic so_d;
    logic [6:0] hold_d;

    // Rising select ends the frame at once, with or without clock edges
    assign link_rst = LNK.cs_n | RST;

    // Config strap changes rarely; it settles in the first opcode bits
    sfr_sync3 u_page_sync (
        .clk(LNK.sck),
        .rst(link_rst),
        .d(PAGE_256),
        .q(p256)
    );

    // Frame activity seen from the system clock
    sfr_sync3 u_act_sync (
        .clk(CLK),
        .rst(RST),
        .d(~LNK.cs_n),
        .q(READ_ACTIVE)
    );

    assign op_in = {sr_q[6:0], LNK.si};
    assign addr_in = {sr_q[22:0], LNK.si};
    assign op_done = cnt_q == `SFR_CNT_OP_LAST;
    assign addr_done = cnt_q == `SFR_CNT_ADDR_LAST;
    assign hdr = sfr_hdr_bits(op_q);
    assign in_data = op_ok_q && (cnt_q >= hdr);
    assign byte_end = in_data && (cnt_q[2:0] == 3'h7);
    assign first_bit = cnt_q[2:0] == 3'h0;

    assign is_array = (op_q == `SFR_OP_FAST) || (op_q == `SFR_OP_SLOW);
    assign is_buf_in = (op_in == `SFR_OP_BUF_FAST) ||
        (op_in == `SFR_OP_BUF_SLOW);

    // Binary mode never looks at the extra ninth byte bit
    assign last_byte = p256 ? `SFR_LAST_256 : `SFR_LAST_264;
    // A byte offset past the page end is treated as the end
    assign at_end = byte_q >= last_byte;

    assign start_page = sel_buf_q ? 9'h000 :
        page_field(p256, addr_in);
    assign start_byte = byte_field(p256, addr_in);

    // Page and buffer reads keep their page; array reads step on and
    // the page count wraps at 512, which closes the array loop
    assign next_page = (at_end && is_array) ?
        9'(page_q + 9'h001) : page_q;
    assign next_byte = at_end ? 9'h000 :
        9'(byte_q + 9'h001);

    // Once data flows only the bit-in-byte count moves
    assign cnt_d = in_data ? {cnt_q[6:3], 3'(cnt_q[2:0] + 3'h1)} :
        ((cnt_q == `SFR_CNT_MAX) ? cnt_q :
        7'(cnt_q + 7'h01));

    // Input side samples on the rising clock in both idle levels
    always_ff @(posedge LNK.sck or posedge link_rst) begin
        if (link_rst) begin
            cnt_q <= 7'h00;
            sr_q <= 24'h000000;
        end else begin
            cnt_q <= cnt_d;
            sr_q <= {sr_q[22:0], LNK.si};
        end
    end

    always_ff @(posedge LNK.sck or posedge link_rst) begin
        if (link_rst) begin
            op_q <= 8'h00;
            op_ok_q <= 1'b0;
            sel_buf_q <= 1'b0;
        end else if (op_done) begin
            op_q <= op_in;
            op_ok_q <= sfr_op_known(op_in);
            // Array and page reads never address the buffer
            sel_buf_q <= is_buf_in;
        end
    end

    // Pointer is ready before the first data bit of each byte
    always_ff @(posedge LNK.sck or posedge link_rst) begin
        if (link_rst) begin
            page_q <= 9'h000;
            byte_q <= 9'h000;
        end else if (addr_done) begin
            page_q <= start_page;
            byte_q <= start_byte;
        end else if (byte_end) begin
            page_q <= next_page;
            byte_q <= next_byte;
        end
    end

    // A fresh byte is taken at its first bit, else the held rest shifts
    assign so_d = first_bit ? RD_DATA[7] : hold_q[6];
    assign hold_d = first_bit ? RD_DATA[6:0] :
        {hold_q[5:0], 1'b0};

    // Output side drives on the falling clock, one bit each cycle
    always_ff @(negedge LNK.sck or posedge link_rst) begin
        if (link_rst) begin
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
            hold_q <= 7'h00;
        end else if (in_data) begin
            so_oe_q <= 1'b1;
            so_q <= so_d;
            hold_q <= hold_d;
        end
    end

    // Read-only path: the memory is addressed, never written
    assign ADDR_PAGE = page_q;
    assign ADDR_BYTE = byte_q;
    assign SEL_BUF = sel_buf_q;
    assign LNK.so = so_q;
    assign LNK.so_oe = so_oe_q;
endmodule // sfr_dev

// ---- logic/sfr_host.sv ----
// Host controller end: frames read commands and collects data bytes
`timescale 1ns/100ps
`include "sfr_cfg.svh"
module sfr_host (
    input wire logic CLK,
    input wire logic RST,
    input wire logic START,
    input wire logic MODE3,
    input wire sfr_pkg::sfr_op_t OPCODE,
    input wire sfr_pkg::sfr_addr_t ADDR,
    input wire logic [7:0] NBYTES,
    output logic BUSY,
    output logic DONE,
    output logic RX_VALID,
    output sfr_pkg::sfr_byte_t RX_DATA,
    sfr_link_if.host LNK
);
    import sfr_pkg::*;

    sfr_hst_state_t state_q;
    logic [3:0] div_q;
    logic [11:0] bit_q;
    logic [11:0] total_q;
    sfr_cnt_t hdr_q;
    logic [31:0] tx_q;
    sfr_byte_t rx_q;
    logic mode3_q;
    logic cs_n_q;
    logic sck_q;
    logic si_q;
    logic busy_q;
    logic done_q;
    logic rx_valid_q;
    sfr_byte_t rx_data_q;
    logic so_s;
    logic tick;
    logic rise;
    logic fall;
    logic last_rise;
    logic data_bit;
    sfr_byte_t rx_d;
    sfr_cnt_t hdr_in;

    sfr_sync3 u_so_sync (
        .clk(CLK),
        .rst(RST),
        .d(LNK.so_line),
        .q(so_s)
    );

    // Half period of six cycles leaves room for the three-stage sync
    assign tick = div_q == 4'(`SFR_SCK_HALF - 4'h1);
    assign rise = (state_q == SFR_SHIFT) && tick && !sck_q;
    assign fall = (state_q == SFR_SHIFT) && tick && sck_q;
    assign last_rise = rise && (bit_q == 12'(total_q - 12'h001));
    assign data_bit = bit_q >= {5'h00, hdr_q};
    assign rx_d = {rx_q[6:0], so_s};
    assign hdr_in = sfr_hdr_bits(OPCODE);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            div_q <= 4'h0;
        end else if (tick || state_q == SFR_IDLE) begin
            div_q <= 4'h0;
        end else begin
            div_q <= 4'(div_q + 4'h1);
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_q <= SFR_IDLE;
            bit_q <= 12'h000;
            total_q <= 12'h000;
            hdr_q <= 7'h00;
            tx_q <= 32'h00000000;
            rx_q <= 8'h00;
            mode3_q <= 1'b0;
            cs_n_q <= 1'b1;
            sck_q <= 1'b0;
            si_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            rx_valid_q <= 1'b0;
            rx_data_q <= 8'h00;
        end else begin
            done_q <= 1'b0;
            rx_valid_q <= 1'b0;
            case (state_q)
                SFR_IDLE: begin
                    sck_q <= MODE3;
                    if (START) begin
                        mode3_q <= MODE3;
                        hdr_q <= hdr_in;
                        total_q <= {5'h00, hdr_in} +
                            {1'b0, NBYTES, 3'h0};
                        tx_q <= {OPCODE, ADDR};
                        si_q <= OPCODE[7];
                        bit_q <= 12'h000;
                        cs_n_q <= 1'b0;
                        busy_q <= 1'b1;
                        state_q <= SFR_LEAD;
                    end
                end
                SFR_LEAD: begin
                    if (tick) begin
                        state_q <= SFR_SHIFT;
                    end
                end
                SFR_SHIFT: begin
                    if (tick) begin
                        sck_q <= ~sck_q;
                    end
                    if (rise) begin
                        bit_q <= 12'(bit_q + 12'h001);
                        if (data_bit) begin
                            rx_q <= rx_d;
                            if (bit_q[2:0] == 3'h7) begin
                                rx_data_q <= rx_d;
                                rx_valid_q <= 1'b1;
                            end
                        end
                        if (last_rise) begin
                            state_q <= SFR_TAIL;
                        end
                    end
                    // Mode 3 opens with a fall that must not shift
                    if (fall && bit_q != 12'h000) begin
                        tx_q <= {tx_q[30:0], 1'b0};
                        si_q <= tx_q[30];
                    end
                end
                SFR_TAIL: begin
                    if (tick) begin
                        if (sck_q != mode3_q) begin
                            sck_q <= mode3_q;
                        end else begin
                            cs_n_q <= 1'b1;
                            busy_q <= 1'b0;
                            done_q <= 1'b1;
                            state_q <= SFR_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= SFR_IDLE;
                    cs_n_q <= 1'b1;
                end
            endcase
        end
    end

    assign LNK.cs_n = cs_n_q;
    assign LNK.sck = sck_q;
    assign LNK.si = si_q;
    assign BUSY = busy_q;
    assign DONE = done_q;
    assign RX_VALID = rx_valid_q;
    assign RX_DATA = rx_data_q;
endmodule // sfr_host

// ---- logic/sfr_link_if.sv ----
// Serial chip-select link between host controller and flash device
`timescale 1ns/100ps
interface sfr_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic so_line;

    // Released output reads high, as with a pull-up on the board
    assign so_line = so_oe ? so : 1'b1;

    modport dev (
        input cs_n,
        input sck,
        input si,
        output so,
        output so_oe
    );

    modport host (
        output cs_n,
        output sck,
        output si,
        input so_line
    );
endinterface

// ---- logic/sfr_pkg.sv ----
// Types and opcode decoding of the serial flash read link
package sfr_pkg;
`include "sfr_cfg.svh"

    typedef logic [7:0] sfr_op_t;
    typedef logic [7:0] sfr_byte_t;
    typedef logic [8:0] sfr_ptr_t;
    typedef logic [6:0] sfr_cnt_t;
    typedef logic [23:0] sfr_addr_t;

    typedef enum logic [1:0] {
        SFR_IDLE = 2'h0,
        SFR_LEAD = 2'h1,
        SFR_SHIFT = 2'h3,
        SFR_TAIL = 2'h2
    } sfr_hst_state_t;

    function automatic logic sfr_op_known(sfr_op_t op);
        return (op == `SFR_OP_FAST) || (op == `SFR_OP_SLOW) ||
            (op == `SFR_OP_PAGE) || (op == `SFR_OP_BUF_FAST) ||
            (op == `SFR_OP_BUF_SLOW);
    endfunction

    // Bits clocked in before the first data bit is driven
    function automatic sfr_cnt_t sfr_hdr_bits(sfr_op_t op);
        case (op)
            `SFR_OP_FAST: return `SFR_HDR_FAST;
            `SFR_OP_SLOW: return `SFR_HDR_SLOW;
            `SFR_OP_PAGE: return `SFR_HDR_PAGE;
            `SFR_OP_BUF_FAST: return `SFR_HDR_BUF;
            `SFR_OP_BUF_SLOW: return `SFR_HDR_BUF;
            default: return `SFR_HDR_NONE;
        endcase
    endfunction
endpackage

// ---- logic/sfr_sync3.sv ----
// Three-stage synchroniser that passes a level once two stages agree
`timescale 1ns/100ps
module sfr_sync3 (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic q_q;

    assign q = q_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            q_q <= 1'b0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                q_q <= s3_q;
            end
        end
    end
endmodule // sfr_sync3

// ---- tb/serial_flash_read_commands_tb.sv ----
// Self-checking bench joining host and device ends of the read link
`timescale 1ns/100ps
`include "sfr_cfg.svh"
`define CHK(nm, ex, got) begin \
    tests_run++; \
    if ((got) !== (ex)) begin \
        n_errors++; \
        $display("MISMATCH %s exp %0h got %0h", nm, ex, got); \
    end \
end
module serial_flash_read_commands_tb;
    import sfr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic mode3 = 1'b0;
    logic page_256 = 1'b0;
    sfr_op_t opcode = 8'h00;
    sfr_addr_t addr = 24'h000000;
    logic [7:0] nbytes = 8'h00;
    logic busy;
    logic done;
    logic rx_valid;
    sfr_byte_t rx_data;
    sfr_byte_t rd_data;
    sfr_ptr_t addr_page;
    sfr_ptr_t addr_byte;
    logic sel_buf;
    logic read_active;
    int n_errors = 0;
    int tests_run = 0;
    int seed = 14649;
    int cyc = 0;
    sfr_op_t ops [5] = '{`SFR_OP_FAST, `SFR_OP_SLOW, `SFR_OP_PAGE,
        `SFR_OP_BUF_FAST, `SFR_OP_BUF_SLOW};

    sfr_link_if lnk ();
    sfr_host sfr_host_i (.CLK(clk), .RST(rst), .START(start),
        .MODE3(mode3), .OPCODE(opcode), .ADDR(addr), .NBYTES(nbytes),
        .BUSY(busy), .DONE(done), .RX_VALID(rx_valid), .RX_DATA(rx_data),
        .LNK(lnk.host));
    sfr_dev sfr_dev_i (.CLK(clk), .RST(rst), .PAGE_256(page_256),
        .RD_DATA(rd_data), .ADDR_PAGE(addr_page), .ADDR_BYTE(addr_byte),
        .SEL_BUF(sel_buf), .READ_ACTIVE(read_active), .LNK(lnk.dev));
    sfr_link_asserts sfr_link_asserts_i (.CLK(clk), .RST(rst),
        .cs_n(lnk.cs_n), .sck(lnk.sck), .si(lnk.si), .so(lnk.so),
        .so_oe(lnk.so_oe), .so_line(lnk.so_line));

    // Array and buffer contents differ so a wrong target shows up
    function automatic sfr_byte_t mem(logic b, sfr_ptr_t p, sfr_ptr_t y);
        return b ? (y[7:0] ^ 8'hA5 ^ {y[8], 7'h00}) :
            (p[7:0] + y[7:0] * 8'h03 ^ {p[8], y[8], 6'h00});
    endfunction
    assign rd_data = mem(sel_buf, addr_page, addr_byte);

    always #25 clk = ~clk;

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic run(input sfr_op_t op, input sfr_addr_t a, input int n,
        input logic m3, input logic p256);
        sfr_ptr_t pg;
        sfr_ptr_t by;
        sfr_ptr_t last;
        logic bf;
        logic known;
        logic fin;
        logic wrap;
        int got;
        sfr_byte_t ex;
        pg = p256 ? a[16:8] : a[17:9];
        by = p256 ? {1'b0, a[7:0]} : a[8:0];
        bf = op inside {`SFR_OP_BUF_FAST, `SFR_OP_BUF_SLOW};
        known = bf || op inside {`SFR_OP_FAST, `SFR_OP_SLOW, `SFR_OP_PAGE};
        if (bf) pg = 9'h000;
        last = p256 ? `SFR_LAST_256 : `SFR_LAST_264;
        fin = 1'b0;
        got = 0;
        @(posedge clk);
        #1;
        mode3 = m3;
        page_256 = p256;
        opcode = op;
        addr = a;
        nbytes = 8'(n);
        // Idle sck level settles before the frame opens
        repeat (2) @(posedge clk);
        #1 start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        for (int k = 0; k < 4000 && !fin; k++) begin
            @(negedge clk);
            if (k == 12) begin
                `CHK("busy", 1'b1, busy)
                `CHK("read_active", 1'b1, read_active)
            end
            if (rx_valid === 1'b1) begin
                ex = known ? mem(bf, pg, by) : 8'hFF;
                `CHK("rx_data", ex, rx_data)
                wrap = by >= last;
                by = wrap ? 9'h000 : by + 9'h001;
                if (wrap && !bf && op != `SFR_OP_PAGE) pg = pg + 9'h001;
                got++;
            end
            if (done === 1'b1) fin = 1'b1;
        end
        `CHK("done", 1'b1, fin)
        `CHK("byte_count", n, got)
        repeat (8) @(negedge clk);
        `CHK("read_idle", 1'b0, read_active)
    endtask

    initial begin
        sfr_addr_t a;
        int r;
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        // Each opcode at both page sizes, crossing a page or buffer end
        for (int i = 0; i < 10; i++) begin
            a = i[0] ? {7'h00, 9'h005, 8'hFE} : {6'h00, 9'h005, 9'h106};
            run(ops[i / 2], a, 4, i[0] ^ i[1], i[0]);
        end
        run(`SFR_OP_FAST, {6'h00, 9'h1FF, 9'h106}, 3, 1'b0, 1'b0);
        run(`SFR_OP_SLOW, {7'h00, 9'h1FF, 8'hFF}, 3, 1'b1, 1'b1);
        run(8'h5A, 24'h000000, 2, 1'b0, 1'b0);
        run(`SFR_OP_PAGE, 24'h000123, 0, 1'b1, 1'b1);
        for (int i = 0; i < 16; i++) begin
            a = 24'($random(seed));
            // Keep 264-mode offsets at or below the last byte
            if (a[8]) a[7:3] = 5'h00;
            r = $random(seed);
            run(ops[$unsigned(r) % 5], a, 1 + $unsigned(r[10:8]) % 5,
                r[12], r[13]);
        end
        report_and_stop();
    end
endmodule // serial_flash_read_commands_tb

// ---- tb/sfr_link_asserts.sv ----
// Concurrent checks on the serial read link between host and device
`timescale 1ns/100ps
`include "sfr_cfg.svh"
module sfr_link_asserts (
    input wire logic CLK,
    input wire logic RST,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe,
    input wire logic so_line
);
    logic sck_q;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] op_q;
    logic [7:0] op_d;
    logic [7:0] hdr;
    wire rise = sck & ~sck_q;

    // Oversampled on CLK: sck is a divided CLK, so no sck edge is missed
    assign cnt_d = cs_n ? 8'h00 :
        (rise && cnt_q != 8'hFF) ? cnt_q + 8'h01 : cnt_q;
    assign op_d = (rise && cnt_q < 8'h08) ? {op_q[6:0], si} : op_q;
    assign hdr = (op_q == `SFR_OP_SLOW) ? 8'h20 :
        (op_q == `SFR_OP_PAGE) ? 8'h40 :
        (op_q inside {`SFR_OP_FAST, `SFR_OP_BUF_FAST,
            `SFR_OP_BUF_SLOW}) ? 8'h28 : 8'h00;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sck_q <= 1'b0;
            cnt_q <= 8'h00;
            op_q <= 8'h00;
        end else begin
            sck_q <= sck;
            cnt_q <= cnt_d;
            op_q <= op_d;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    a_idle_released: assert property (cs_n |-> !so_oe && so_line)
        else $error("so driven while deselected");
    a_frame_lead: assert property ($fell(cs_n) |-> $stable(sck)[*5])
        else $error("sck moved right after select fell");
    a_sck_half: assert property (
        !cs_n && $changed(sck) |=> $stable(sck)[*5])
        else $error("sck half period too short");
    a_oe_on_fall: assert property ($rose(so_oe) |-> !sck)
        else $error("output enabled away from a falling edge");
    a_so_on_fall: assert property (!cs_n && $changed(so) |-> !sck)
        else $error("so changed while sck high");
    a_header_len: assert property (
        $rose(so_oe) |-> hdr != 8'h00 && cnt_q == hdr)
        else $error("data started after wrong header length");
    a_oe_until_cs: assert property ($fell(so_oe) |-> cs_n)
        else $error("output released inside a frame");
    a_no_early_oe: assert property (cnt_q < 8'h20 |-> !so_oe)
        else $error("output driven during opcode or address");

    c_slow_read: cover property ($rose(so_oe) && op_q == `SFR_OP_SLOW);
    c_page_read: cover property ($rose(so_oe) && op_q == `SFR_OP_PAGE);
    c_buf_read: cover property ($rose(so_oe) && op_q == `SFR_OP_BUF_FAST);
    c_mode3_frame: cover property ($fell(cs_n) && sck);
endmodule // sfr_link_asserts
